// [common/mdu_pkg.sv]
// shared types and constants of the muldiv and stack-limit core
`default_nettype none

package mdu_pkg;

   // =========================================================
   // special function register word offsets
   localparam logic [7:0] ADDR_STACK_LOWER_LIMIT = 8'h0B;
   localparam logic [7:0] ADDR_MULDIV_HIGH_WORD = 8'h06;
   localparam logic [7:0] ADDR_MULDIV_LOW_WORD = 8'h07;
   localparam logic [7:0] ADDR_MULDIV_CONTROL = 8'h87;
   localparam logic [7:0] ADDR_CONSTANT_ALL_CLEAR = 8'h8E;
   localparam logic [7:0] ADDR_CONSTANT_ALL_SET = 8'h8F;

   // =========================================================
   // register values and field masks
   localparam logic [15:0] LIMIT_RESET = 16'hFC00;
   localparam logic [15:0] LIMIT_FIXED_ONES = 16'hF800;
   localparam logic [15:0] LIMIT_WRITE_MASK = 16'h07FE;
   localparam logic [15:0] MULDIV_RESET = 16'h0000;
   localparam logic [15:0] CONSTANT_SET_VALUE = 16'hFFFF;
   localparam logic [15:0] CONSTANT_CLEAR_VALUE = 16'h0000;
   localparam logic [15:0] UNMAPPED_READ = 16'h0000;

   // =========================================================
   // iteration counts
   localparam logic [4:0] STEP_FIRST = 5'h00;
   localparam logic [4:0] STEP_ONE = 5'h01;
   localparam logic [4:0] STEP_LAST = 5'h0F;
   localparam logic [4:0] STEP_FIX = 5'h10;
   localparam logic [3:0] NORM_TOP = 4'hF;

   // =========================================================
   // types
   typedef enum logic [2:0] {
      signed_product_op = 3'h0,
      unsigned_product_op = 3'h1,
      signed_short_quotient_op = 3'h2,
      unsigned_short_quotient_op = 3'h3,
      signed_long_quotient_op = 3'h4,
      unsigned_long_quotient_op = 3'h5,
      normalize_count_op = 3'h6
   } mdu_op_code_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01,
      ST_FIX = 2'b11
   } mdu_state_type;

   typedef struct packed {
      logic [2:0] spare_hi;
      logic [4:0] step;
      logic active;
      logic neg_rem;
      logic neg_quo;
      logic muldiv_in_use_flag;
      logic spare_lo;
      mdu_op_code_type op;
   } mdu_ctl_type;

   localparam mdu_ctl_type CTL_RESET = '0;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [15:0] wdata;
   } mdu_sfr_req_type;

   typedef struct packed {
      logic start;
      logic abort;
      mdu_op_code_type code;
      logic [15:0] a;
      logic [15:0] b;
   } mdu_op_req_type;

   function automatic logic op_is_signed(input mdu_op_code_type c);
      return (c == signed_product_op) || (c == signed_short_quotient_op) ||
             (c == signed_long_quotient_op);
   endfunction

   function automatic logic op_is_div(input mdu_op_code_type c);
      return (c == signed_short_quotient_op) || (c == unsigned_short_quotient_op) ||
             (c == signed_long_quotient_op) || (c == unsigned_long_quotient_op);
   endfunction

endpackage

`default_nettype wire

// [hw/mdu_norm_count.sv]
// leading-zero count of a word for the normalize operation
`default_nettype none

module mdu_norm_count
   import mdu_pkg::*;
(
   input wire logic [15:0] operand_i,
   output logic [3:0] count_o
);

   // =========================================================
   // lowest set bit scanned first, highest set bit wins
   always_comb begin
      count_o = 4'h0;
      for (int i = 0; i < 16; i++) begin
         if (operand_i[i]) begin
            count_o = NORM_TOP - 4'(i);
         end
      end
   end

endmodule // mdu_norm_count

`default_nettype wire

// [hw/mdu_core.sv]
// muldiv unit, stack lower-limit check and constant registers of the cpu core
`default_nettype none

// =========================================================
// What this block does
// - underflow when stack pointer is strictly above the lower-limit register
// - compare after each stack release event and raise a trap on underflow
// - limit bit 0 always zero, bits 11 to 15 always one
// - limit holds only even addresses from F800 to FFFE
// - limit register resets to FC00
// - product upper half goes to the high word
// - product lower half goes to the low word
// - division remainder lands in the high word
// - division quotient lands in the low word
// - software write of high or low word sets the in-use flag
// - software read of the low word clears the in-use flag
// - control register tracks progress on every cycle of a multiply or divide; a normalize count leaves it unchanged
// - high, low and control words reset to zero
// - all-set constant reads ones, ignores writes
// - all-clear constant reads zeros, ignores writes
// - both constants readable through the special register port
// - signed and unsigned 16 by 16 multiply into the word pair
// - signed and unsigned 16/16 and 32/16 division
// - normalize count gives shifts to bring top one bit to the top
module mdu_core
   import mdu_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire mdu_sfr_req_type sfr_i,
   output logic [15:0] sfr_rdata_o,
   input wire logic [15:0] stack_pointer_i,
   input wire logic stack_release_i,
   output logic underflow_trap_o,
   input wire mdu_op_req_type op_i,
   output logic op_busy_o,
   output logic op_done_o,
   output logic [3:0] norm_count_o
);

   // =========================================================
   // registers and decode
   logic [15:0] stack_lower_limit;
   logic [15:0] muldiv_high_word;
   logic [15:0] muldiv_low_word;
   mdu_ctl_type muldiv_control;
   mdu_ctl_type next_control;
   mdu_ctl_type eng_control;
   mdu_state_type state;
   mdu_state_type next_state;
   logic [15:0] operand;
   logic [15:0] next_operand;
   logic [15:0] next_high;
   logic [15:0] next_low;
   logic [15:0] read_word;
   logic [3:0] norm_value;
   logic eng_update;
   logic accept;
   logic wr_limit;
   logic wr_high;
   logic wr_low;
   logic wr_ctl;
   logic rd_low;

   assign wr_limit = sfr_i.wr && (sfr_i.addr == ADDR_STACK_LOWER_LIMIT);
   assign wr_high = sfr_i.wr && (sfr_i.addr == ADDR_MULDIV_HIGH_WORD);
   assign wr_low = sfr_i.wr && (sfr_i.addr == ADDR_MULDIV_LOW_WORD);
   assign wr_ctl = sfr_i.wr && (sfr_i.addr == ADDR_MULDIV_CONTROL);
   assign rd_low = sfr_i.rd && (sfr_i.addr == ADDR_MULDIV_LOW_WORD);
   assign accept = op_i.start && (state == ST_IDLE);
   assign op_busy_o = (state != ST_IDLE);

   // =========================================================
   // stack lower limit and underflow trap
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         stack_lower_limit <= LIMIT_RESET;
      end else if (wr_limit) begin
         stack_lower_limit <= (sfr_i.wdata & LIMIT_WRITE_MASK) | LIMIT_FIXED_ONES;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         underflow_trap_o <= 1'b0;
      end else begin
         underflow_trap_o <= stack_release_i && (stack_pointer_i > stack_lower_limit);
      end
   end

   // =========================================================
   // register read port, data one cycle after the read
   always_comb begin
      read_word = UNMAPPED_READ;
      case (sfr_i.addr)
         ADDR_STACK_LOWER_LIMIT: read_word = stack_lower_limit;
         ADDR_MULDIV_HIGH_WORD: read_word = muldiv_high_word;
         ADDR_MULDIV_LOW_WORD: read_word = muldiv_low_word;
         ADDR_MULDIV_CONTROL: read_word = muldiv_control;
         ADDR_CONSTANT_ALL_SET: read_word = CONSTANT_SET_VALUE;
         ADDR_CONSTANT_ALL_CLEAR: read_word = CONSTANT_CLEAR_VALUE;
         default: read_word = UNMAPPED_READ;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sfr_rdata_o <= UNMAPPED_READ;
      end else if (sfr_i.rd) begin
         sfr_rdata_o <= read_word;
      end
   end

   // =========================================================
   // iterative multiply and divide engine
   logic [16:0] sum17;
   logic [16:0] rem17;
   logic [16:0] diff17;
   logic [31:0] wide;
   logic sgn;

   always_comb begin
      next_state = state;
      eng_update = 1'b0;
      next_high = muldiv_high_word;
      next_low = muldiv_low_word;
      eng_control = muldiv_control;
      next_operand = operand;
      sum17 = '0;
      rem17 = '0;
      diff17 = '0;
      wide = '0;
      sgn = op_is_signed(op_i.code);
      unique case (state)
         ST_IDLE: begin
            if (accept && (op_i.code != normalize_count_op) && !op_i.abort) begin
               eng_update = 1'b1;
               next_operand = (sgn && op_i.b[15]) ? -op_i.b : op_i.b;
               if (muldiv_control.active) begin
                  // resume a restored operation
                  next_state = (muldiv_control.step == STEP_FIX) ? ST_FIX : ST_RUN;
               end else begin
                  eng_control.op = op_i.code;
                  eng_control.active = 1'b1;
                  eng_control.step = STEP_FIRST;
                  eng_control.neg_quo = 1'b0;
                  eng_control.neg_rem = 1'b0;
                  next_state = ST_RUN;
                  case (op_i.code)
                     signed_product_op, unsigned_product_op: begin
                        next_high = MULDIV_RESET;
                        next_low = (sgn && op_i.a[15]) ? -op_i.a : op_i.a;
                        eng_control.neg_quo = sgn && (op_i.a[15] ^ op_i.b[15]);
                     end
                     signed_short_quotient_op, unsigned_short_quotient_op: begin
                        next_high = MULDIV_RESET;
                        next_low = (sgn && muldiv_low_word[15]) ? -muldiv_low_word
                                                                : muldiv_low_word;
                        eng_control.neg_quo = sgn && (muldiv_low_word[15] ^ op_i.b[15]);
                        eng_control.neg_rem = sgn && muldiv_low_word[15];
                     end
                     signed_long_quotient_op, unsigned_long_quotient_op: begin
                        wide = {muldiv_high_word, muldiv_low_word};
                        if (sgn && muldiv_high_word[15]) begin
                           wide = -wide;
                        end
                        next_high = wide[31:16];
                        next_low = wide[15:0];
                        eng_control.neg_quo = sgn && (muldiv_high_word[15] ^ op_i.b[15]);
                        eng_control.neg_rem = sgn && muldiv_high_word[15];
                     end
                     default: begin
                        eng_update = 1'b0;
                        eng_control = muldiv_control;
                        next_state = ST_IDLE;
                     end
                  endcase
               end
            end
         end
         ST_RUN: begin
            if (op_i.abort) begin
               next_state = ST_IDLE;
            end else begin
               eng_update = 1'b1;
               if (op_is_div(muldiv_control.op)) begin
                  // restoring step: remainder in high word, quotient shifts into low
                  rem17 = {muldiv_high_word, muldiv_low_word[15]};
                  diff17 = rem17 - {1'b0, operand};
                  if (!diff17[16]) begin
                     next_high = diff17[15:0];
                     next_low = {muldiv_low_word[14:0], 1'b1};
                  end else begin
                     next_high = rem17[15:0];
                     next_low = {muldiv_low_word[14:0], 1'b0};
                  end
               end else begin
                  // shift-add step: multiplier drains out of the low word
                  sum17 = {1'b0, muldiv_high_word} +
                          (muldiv_low_word[0] ? {1'b0, operand} : 17'h00000);
                  next_high = sum17[16:1];
                  next_low = {sum17[0], muldiv_low_word[15:1]};
               end
               eng_control.step = muldiv_control.step + STEP_ONE;
               if (muldiv_control.step == STEP_LAST) begin
                  next_state = ST_FIX;
               end
            end
         end
         ST_FIX: begin
            if (op_i.abort) begin
               next_state = ST_IDLE;
            end else begin
               eng_update = 1'b1;
               if (op_is_div(muldiv_control.op)) begin
                  if (muldiv_control.neg_quo) begin
                     next_low = -muldiv_low_word;
                  end
                  if (muldiv_control.neg_rem) begin
                     next_high = -muldiv_high_word;
                  end
               end else if (muldiv_control.neg_quo) begin
                  wide = -{muldiv_high_word, muldiv_low_word};
                  next_high = wide[31:16];
                  next_low = wide[15:0];
               end
               eng_control.active = 1'b0;
               eng_control.step = STEP_FIRST;
               eng_control.neg_quo = 1'b0;
               eng_control.neg_rem = 1'b0;
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state <= ST_IDLE;
         operand <= MULDIV_RESET;
      end else begin
         state <= next_state;
         operand <= next_operand;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         muldiv_high_word <= MULDIV_RESET;
         muldiv_low_word <= MULDIV_RESET;
      end else if (eng_update) begin
         muldiv_high_word <= next_high;
         muldiv_low_word <= next_low;
      end else begin
         if (wr_high) begin
            muldiv_high_word <= sfr_i.wdata;
         end
         if (wr_low) begin
            muldiv_low_word <= sfr_i.wdata;
         end
      end
   end

   // =========================================================
   // control word: engine over software, flag set over clear
   always_comb begin
      next_control = muldiv_control;
      if (wr_ctl) begin
         next_control = mdu_ctl_type'(sfr_i.wdata);
      end
      if (eng_update) begin
         next_control = eng_control;
      end
      if (rd_low) begin
         next_control.muldiv_in_use_flag = 1'b0;
      end
      if (wr_high || wr_low) begin
         next_control.muldiv_in_use_flag = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         muldiv_control <= CTL_RESET;
      end else begin
         muldiv_control <= next_control;
      end
   end

   // =========================================================
   // normalize count and completion pulse
   mdu_norm_count u_norm (
      .operand_i(op_i.a),
      .count_o(norm_value)
   );

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         norm_count_o <= 4'h0;
         op_done_o <= 1'b0;
      end else begin
         op_done_o <= ((state == ST_FIX) && !op_i.abort) ||
                      (accept && (op_i.code == normalize_count_op));
         if (accept && (op_i.code == normalize_count_op)) begin
            norm_count_o <= norm_value;
         end
      end
   end

   // =========================================================
   // assertion helpers: operands of a fresh uninterrupted operation
   logic [15:0] cap_a;
   logic [15:0] cap_b;
   logic [31:0] cap_dvd;
   mdu_op_code_type cap_code;
   logic cap_clean;
   logic [15:0] norm_shifted;

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cap_a <= '0;
         cap_b <= '0;
         cap_dvd <= '0;
         cap_code <= normalize_count_op;
         cap_clean <= 1'b0;
      end else if (accept && !op_i.abort) begin
         cap_a <= op_i.a;
         cap_b <= op_i.b;
         cap_dvd <= {muldiv_high_word, muldiv_low_word};
         cap_code <= op_i.code;
         cap_clean <= !muldiv_control.active;
      end else if (op_i.abort) begin
         cap_clean <= 1'b0;
      end
   end

   assign norm_shifted = cap_a << norm_count_o;

   // =========================================================
   // assertions
   property p_underflow_trap;
      @(posedge core_clk_i) disable iff (!nrst_i)
      (stack_release_i && (stack_pointer_i > stack_lower_limit)) |=> underflow_trap_o;
   endproperty
   a_underflow_trap: assert property (p_underflow_trap) else $error("underflow missed");

   property p_trap_single;
      @(posedge core_clk_i) disable iff (!nrst_i)
      !(stack_release_i && (stack_pointer_i > stack_lower_limit)) |=> !underflow_trap_o;
   endproperty
   a_trap_single: assert property (p_trap_single) else $error("spurious trap");

   property p_limit_fixed;
      @(posedge core_clk_i) disable iff (!nrst_i)
      ((stack_lower_limit & ~LIMIT_WRITE_MASK) == LIMIT_FIXED_ONES);
   endproperty
   a_limit_fixed: assert property (p_limit_fixed) else $error("limit fixed bits");

   property p_limit_write;
      @(posedge core_clk_i) disable iff (!nrst_i)
      wr_limit |=> (stack_lower_limit ==
                    (($past(sfr_i.wdata) & LIMIT_WRITE_MASK) | LIMIT_FIXED_ONES));
   endproperty
   a_limit_write: assert property (p_limit_write) else $error("limit write");

   property p_unsigned_product;
      @(posedge core_clk_i) disable iff (!nrst_i)
      (op_done_o && cap_clean && (cap_code == unsigned_product_op)) |->
      ({muldiv_high_word, muldiv_low_word} == (32'(cap_a) * 32'(cap_b)));
   endproperty
   a_unsigned_product: assert property (p_unsigned_product) else $error("unsigned product");

   property p_signed_product;
      @(posedge core_clk_i) disable iff (!nrst_i)
      (op_done_o && cap_clean && (cap_code == signed_product_op)) |->
      ($signed({muldiv_high_word, muldiv_low_word}) == ($signed(cap_a) * $signed(cap_b)));
   endproperty
   a_signed_product: assert property (p_signed_product) else $error("signed product");

   property p_unsigned_long_div;
      @(posedge core_clk_i) disable iff (!nrst_i)
      (op_done_o && cap_clean && (cap_code == unsigned_long_quotient_op) &&
       (cap_dvd[31:16] < cap_b)) |->
      ((muldiv_low_word == 16'(cap_dvd / 32'(cap_b))) &&
       (muldiv_high_word == 16'(cap_dvd % 32'(cap_b))));
   endproperty
   a_unsigned_long_div: assert property (p_unsigned_long_div) else $error("long division");

   property p_signed_short_div;
      @(posedge core_clk_i) disable iff (!nrst_i)
      (op_done_o && cap_clean && (cap_code == signed_short_quotient_op) &&
       (cap_b != 16'h0000) && (cap_b != 16'hFFFF)) |->
      (($signed(muldiv_low_word) == ($signed(cap_dvd[15:0]) / $signed(cap_b))) &&
       ($signed(muldiv_high_word) == ($signed(cap_dvd[15:0]) % $signed(cap_b))));
   endproperty
   a_signed_short_div: assert property (p_signed_short_div) else $error("short division");

   property p_in_use_set;
      @(posedge core_clk_i) disable iff (!nrst_i)
      (wr_high || wr_low) |=> muldiv_control.muldiv_in_use_flag;
   endproperty
   a_in_use_set: assert property (p_in_use_set) else $error("in-use not set");

   property p_in_use_clear;
      @(posedge core_clk_i) disable iff (!nrst_i)
      (rd_low && !wr_high && !wr_low) |=> !muldiv_control.muldiv_in_use_flag;
   endproperty
   a_in_use_clear: assert property (p_in_use_clear) else $error("in-use not cleared");

   property p_step_progress;
      @(posedge core_clk_i) disable iff (!nrst_i)
      ((state == ST_RUN) && !op_i.abort && (muldiv_control.step == STEP_LAST)) |=>
      (state == ST_FIX) && (muldiv_control.step == STEP_FIX) ##1 op_done_o;
   endproperty
   a_step_progress: assert property (p_step_progress) else $error("step count");

   property p_constants;
      @(posedge core_clk_i) disable iff (!nrst_i)
      (sfr_i.rd && (sfr_i.addr == ADDR_CONSTANT_ALL_SET)) |=>
      (sfr_rdata_o == CONSTANT_SET_VALUE);
   endproperty
   a_constants: assert property (p_constants) else $error("constant read");

   property p_zeros;
      @(posedge core_clk_i) disable iff (!nrst_i)
      (sfr_i.rd && (sfr_i.addr == ADDR_CONSTANT_ALL_CLEAR)) |=>
      (sfr_rdata_o == CONSTANT_CLEAR_VALUE);
   endproperty
   a_zeros: assert property (p_zeros) else $error("zero read");

   property p_normalize;
      @(posedge core_clk_i) disable iff (!nrst_i)
      (accept && !op_i.abort && (op_i.code == normalize_count_op) &&
       (op_i.a != 16'h0000)) |=> op_done_o && norm_shifted[15];
   endproperty
   a_normalize: assert property (p_normalize) else $error("normalize count");

   c_product: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
      op_done_o && cap_clean && (cap_code == signed_product_op));
   c_division: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
      op_done_o && cap_clean && (cap_code == unsigned_long_quotient_op));
   c_trap: cover property (@(posedge core_clk_i) disable iff (!nrst_i) underflow_trap_o);
   c_resume: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
      accept && muldiv_control.active);

endmodule // mdu_core

`default_nettype wire

// [verif/testbench.sv]
// self-checking bench of the muldiv, stack-limit and constant registers
`default_nettype none
module testbench
   import mdu_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk_i = 0, nrst_i = 0, rel = 0, trap, busy, done;
   logic [15:0] rdata, sp = 0, r, r2, h, l, a, b, lim;
   logic [3:0] norm;
   logic [31:0] w;
   mdu_sfr_req_type sfr = '0;
   mdu_op_req_type op = '0;
   int n_errors = 0, compares = 0, cyc = 0;
   logic [31:0] seed = 48223;
   logic [7:0] ad[6] = '{ADDR_STACK_LOWER_LIMIT, ADDR_MULDIV_HIGH_WORD, ADDR_MULDIV_LOW_WORD,
                         ADDR_MULDIV_CONTROL, ADDR_CONSTANT_ALL_CLEAR, ADDR_CONSTANT_ALL_SET};
   logic [15:0] ev[6] = '{16'hFC00, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hFFFF};
   mdu_core dut_u (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .sfr_i(sfr), .sfr_rdata_o(rdata),
      .stack_pointer_i(sp), .stack_release_i(rel), .underflow_trap_o(trap), .op_i(op),
      .op_busy_o(busy), .op_done_o(done), .norm_count_o(norm));
   // =========================================================
   // helpers
   initial forever #2 core_clk_i = ~core_clk_i;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [31:0] want(mdu_op_code_type c, logic [15:0] h, l, a, b);
      logic [31:0] dd;
      dd = {h, l};
      case (c)
         signed_product_op: return 32'($signed(a)) * 32'($signed(b));
         unsigned_product_op: return 32'(a) * 32'(b);
         signed_short_quotient_op: return {$signed(l) % $signed(b), $signed(l) / $signed(b)};
         unsigned_short_quotient_op: return {l % b, l / b};
         signed_long_quotient_op: return {16'($signed(dd) % $signed(b)), 16'($signed(dd) / $signed(b))};
         default: return {16'(dd % b), 16'(dd / b)};
      endcase
   endfunction
   task check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] ad_i, input logic [15:0] d);
      sfr.wr = 1; sfr.addr = ad_i; sfr.wdata = d;
      @(posedge core_clk_i); #1 sfr.wr = 0;
      @(posedge core_clk_i); #1;
   endtask
   task rd(input logic [7:0] ad_i, output logic [15:0] d);
      sfr.rd = 1; sfr.addr = ad_i;
      @(posedge core_clk_i); #1 sfr.rd = 0;
      d = rdata;
      @(posedge core_clk_i); #1;
   endtask
   task run(input mdu_op_code_type c, input logic [15:0] a_i, input logic [15:0] b_i);
      op.start = 1; op.code = c; op.a = a_i; op.b = b_i;
      @(posedge core_clk_i); #1 op.start = 0;
      if (c != normalize_count_op) check(busy, 1);
      for (int i = 0; i < 40 && done !== 1'b1; i++) begin
         @(posedge core_clk_i); #1;
      end
      check(done, 1);
      @(posedge core_clk_i); #1;
   endtask
   task final_report();
      $display("compares %0d errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         $display("[ERR] %0t run too long", $time);
         final_report();
      end
   end
   // =========================================================
   // tests
   initial begin
      repeat (2) @(posedge core_clk_i);
      #1 nrst_i = 1;
      foreach (ad[i]) begin
         rd(ad[i], r); check(r, ev[i]);
      end
      rd(8'h55, r); check(r, 16'h0000);
      a = rnd(); wr(ADDR_CONSTANT_ALL_CLEAR, a); wr(ADDR_CONSTANT_ALL_SET, a); wr(8'h55, a);
      rd(ADDR_CONSTANT_ALL_CLEAR, r); check(r, 16'h0000);
      rd(ADDR_CONSTANT_ALL_SET, r); check(r, 16'hFFFF);
      $display("registers done");
      wr(ADDR_MULDIV_LOW_WORD, a); rd(ADDR_MULDIV_CONTROL, r); check(r[4], 1);
      rd(ADDR_MULDIV_LOW_WORD, r); check(r, a);
      rd(ADDR_MULDIV_CONTROL, r); check(r[4], 0);
      wr(ADDR_MULDIV_HIGH_WORD, a); rd(ADDR_MULDIV_CONTROL, r); check(r[4], 1);
      $display("in-use flag done");
      for (int j = 0; j < 4; j++) begin
         a = (j == 0) ? 16'hFFFF : rnd();
         wr(ADDR_STACK_LOWER_LIMIT, a); lim = (a & 16'h07FE) | 16'hF800;
         rd(ADDR_STACK_LOWER_LIMIT, r); check(r, lim);
         foreach (ev[k]) begin
            sp = (k == 0) ? lim : (k == 1) ? lim + 16'h0002 : (k == 2) ? lim - 16'h0002 : rnd();
            rel = 1;
            @(posedge core_clk_i); #1 rel = 0;
            check(trap, sp > lim);
            @(posedge core_clk_i); #1 check(trap, 0);
         end
      end
      $display("stack check done");
      for (int c = 0; c < 6; c++) for (int j = 0; j < 4; j++) begin
         a = (j == 0) ? 16'hFFFF : rnd(); b = (j == 0) ? 16'hFFFF : rnd() | 1;
         if (c > 1 && b == 16'hFFFF) b = 16'h0003;
         l = rnd(); h = (c == 4) ? {16{l[15]}} : 16'(rnd() % b);
         wr(ADDR_MULDIV_HIGH_WORD, h); wr(ADDR_MULDIV_LOW_WORD, l);
         run(mdu_op_code_type'(c), a, b);
         rd(ADDR_MULDIV_HIGH_WORD, r); rd(ADDR_MULDIV_LOW_WORD, r2);
         check({r, r2}, want(mdu_op_code_type'(c), h, l, a, b));
      end
      $display("arithmetic done");
      a = rnd(); b = rnd();
      op.start = 1; op.code = unsigned_product_op; op.a = a; op.b = b;
      @(posedge core_clk_i); #1 op.start = 0;
      repeat (5) @(posedge core_clk_i);
      #1 op.abort = 1;
      @(posedge core_clk_i); #1 op.abort = 0;
      check(busy, 0);
      rd(ADDR_MULDIV_HIGH_WORD, h); rd(ADDR_MULDIV_LOW_WORD, l); rd(ADDR_MULDIV_CONTROL, lim);
      check(lim[7], 1);
      wr(ADDR_MULDIV_CONTROL, 16'h0000);
      r = rnd(); r2 = rnd(); w = want(unsigned_product_op, h, l, r, r2);
      run(unsigned_product_op, r, r2);
      rd(ADDR_MULDIV_HIGH_WORD, r); rd(ADDR_MULDIV_LOW_WORD, r2);
      check({r, r2}, w);
      wr(ADDR_MULDIV_HIGH_WORD, h); wr(ADDR_MULDIV_LOW_WORD, l);
      wr(ADDR_MULDIV_CONTROL, lim);
      run(unsigned_product_op, a, b);
      rd(ADDR_MULDIV_HIGH_WORD, r); rd(ADDR_MULDIV_LOW_WORD, r2);
      check({r, r2}, want(unsigned_product_op, h, l, a, b));
      $display("nesting done");
      for (int j = 0; j < 17; j++) begin
         a = (j == 16) ? 16'h0000 : (16'h8000 >> j) | (rnd() & (16'h7FFF >> j));
         run(normalize_count_op, a, 16'h0000);
         check(norm, j % 16);
      end
      $display("normalize done");
      final_report();
   end
endmodule // testbench
`default_nettype wire
